// >>> design/acsr_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ACSR_REGS_SVH
`define ACSR_REGS_SVH
// Register offsets
`define ACSR_ADDR_CTRL 8'h00
`define ACSR_ADDR_CONV_CYC 8'h04
`define ACSR_ADDR_DATA_CYC 8'h08
`define ACSR_ADDR_STATUS 8'h0C
`define ACSR_ADDR_ACTIVE_CFG 8'h10
`define ACSR_ADDR_PEND_CFG 8'h14
// Register fields
`define ACSR_CTRL_BUSY_BIT 0
`define ACSR_STAT_CONV_BIT 0
`define ACSR_STAT_PEND_BIT 1
`define ACSR_STAT_OVR_BIT 2
`define ACSR_STAT_EMPTY_BIT 3
// Configuration word layout
`define ACSR_CFG_W 14
`define ACSR_RES_W 16
`define ACSR_CFG_DEFAULT 14'h3FFF
`define ACSR_CFG_UPD_BIT 13
`define ACSR_CFG_INCC_HI 12
`define ACSR_CFG_INCC_LO 10
`define ACSR_CFG_INX_HI 9
`define ACSR_CFG_INX_LO 7
`define ACSR_CFG_BW_BIT 6
`define ACSR_CFG_REF_HI 5
`define ACSR_CFG_REF_LO 3
`define ACSR_CFG_RB_BIT 0
`define ACSR_INCC_TEMP 3'h3
`define ACSR_SIGN_FLIP 16'h8000
// Reference arrangements
`define ACSR_REF_INT_2V5 3'h0
`define ACSR_REF_INT_4V096 3'h1
`define ACSR_REF_EXT_BUF_TEMP 3'h2
`define ACSR_REF_EXT_DIR_TEMP 3'h3
`define ACSR_REF_EXT_DIR_OFF 3'h6
`define ACSR_REF_EXT_BUF_OFF 3'h7
// Timing
`define ACSR_CLK_PERIOD_NS 20
`define ACSR_CONV_TIME_NS 2200
`define ACSR_DATA_TIME_NS 1200
`define ACSR_CONV_CYC ((`ACSR_CONV_TIME_NS + `ACSR_CLK_PERIOD_NS - 1) / `ACSR_CLK_PERIOD_NS)
`define ACSR_DATA_CYC (`ACSR_DATA_TIME_NS / `ACSR_CLK_PERIOD_NS)
`endif

// >>> design/acsr_pkg.sv
// Types shared by the converter control block
package acsr_pkg;
`include "acsr_regs.svh"
    typedef enum logic {ST_ACQ, ST_CONV} acsr_state_t;

    typedef struct packed {
        logic [`ACSR_CFG_W-1:0] cfg;
        logic [`ACSR_RES_W-1:0] data;
    } acsr_sample_t;

    typedef struct packed {
        logic bandgap;
        logic drive;
        logic v4096;
        logic buf_en;
        logic temp;
    } acsr_ref_ctl_t;

    function automatic acsr_ref_ctl_t acsr_ref_decode(input logic [2:0] code);
        acsr_ref_ctl_t r;
        r = '0;
        case (code)
            `ACSR_REF_INT_2V5: r = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
            `ACSR_REF_INT_4V096: r = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            `ACSR_REF_EXT_BUF_TEMP: r = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
            `ACSR_REF_EXT_DIR_TEMP: r = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
            `ACSR_REF_EXT_BUF_OFF: r = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
            default: r = '0;
        endcase
        return r;
    endfunction : acsr_ref_decode
endpackage : acsr_pkg

// >>> design/acsr_top.sv
// Converter control: serial access, configuration staging, conversion timing
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "acsr_regs.svh"

module acsr_fifo #(
    parameter int W = 30,
    parameter int D = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    assign in_ready_o = (cnt_reg != (AW+1)'(D));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : acsr_fifo

module acsr_top #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic conv_start_pin_i,
    input wire logic sck_i,
    input wire logic din_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    input wire logic [15:0] adc_raw_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic analog_pwr_o,
    output logic err_corr_en_o,
    output logic bandgap_en_o,
    output logic ref_drive_en_o,
    output logic ref_4v096_o,
    output logic ref_buf_en_o,
    output logic temp_sensor_en_o,
    output logic [2:0] input_cfg_o,
    output logic [2:0] chan_sel_o,
    output logic bw_quarter_o
);
    localparam int TXW = 1 + `ACSR_RES_W + `ACSR_CFG_W;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage one feeds stage two only
    logic [2:0] cnv_s;
    logic [2:0] sck_s;
    logic [1:0] din_s;
    logic cnv_rise;
    logic cnv_fall;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // Idle high, so a pin already high at release is no start edge
            cnv_s <= '1;
            sck_s <= '0;
            din_s <= '0;
        end else begin
            cnv_s <= {cnv_s[1:0], conv_start_pin_i};
            sck_s <= {sck_s[1:0], sck_i};
            din_s <= {din_s[0], din_i};
        end
    end

    assign cnv_rise = cnv_s[1] && !cnv_s[2];
    assign cnv_fall = !cnv_s[1] && cnv_s[2];
    assign sck_rise = sck_s[1] && !sck_s[2] && !cnv_s[1];
    assign sck_fall = !sck_s[1] && sck_s[2] && !cnv_s[1];

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    logic busy_mode_reg;
    logic [15:0] conv_cyc_reg;
    logic [15:0] data_cyc_reg;
    logic overrun_reg;
    logic [31:0] rdata_reg;
    logic [`ACSR_CFG_W-1:0] active_cfg_reg;
    logic [`ACSR_CFG_W-1:0] pend_cfg_reg;
    logic pend_valid_reg;
    acsr_pkg::acsr_state_t state_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic conv_end;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_mode_reg <= 1'b0;
            conv_cyc_reg <= 16'(`ACSR_CONV_CYC);
            data_cyc_reg <= 16'(`ACSR_DATA_CYC);
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `ACSR_ADDR_CTRL: busy_mode_reg <= reg_wdata_i[`ACSR_CTRL_BUSY_BIT];
                `ACSR_ADDR_CONV_CYC: conv_cyc_reg <= reg_wdata_i[15:0];
                `ACSR_ADDR_DATA_CYC: data_cyc_reg <= reg_wdata_i[15:0];
                default: ;
            endcase
        end
    end

    // Lost result sticks; a new loss beats a clear in the same cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            overrun_reg <= 1'b0;
        end else if (conv_end && !fifo_in_ready) begin
            overrun_reg <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == `ACSR_ADDR_STATUS
                     && reg_wdata_i[`ACSR_STAT_OVR_BIT]) begin
            overrun_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `ACSR_ADDR_CTRL: rdata_reg <= {31'h0, busy_mode_reg};
                `ACSR_ADDR_CONV_CYC: rdata_reg <= {16'h0, conv_cyc_reg};
                `ACSR_ADDR_DATA_CYC: rdata_reg <= {16'h0, data_cyc_reg};
                `ACSR_ADDR_STATUS: rdata_reg <= {28'h0, !fifo_out_valid, overrun_reg,
                                                 pend_valid_reg, state_reg == acsr_pkg::ST_CONV};
                `ACSR_ADDR_ACTIVE_CFG: rdata_reg <= {18'h0, active_cfg_reg};
                `ACSR_ADDR_PEND_CFG: rdata_reg <= {18'h0, pend_cfg_reg};
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end
    assign reg_rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Conversion timing
    logic [15:0] conv_cnt_reg;
    logic [`ACSR_CFG_W-1:0] conv_cfg_reg;

    assign conv_end = state_reg == acsr_pkg::ST_CONV && conv_cnt_reg >= conv_cyc_reg - 16'h1;

    // Start depends only on the pin, never on serial clock state
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= acsr_pkg::ST_ACQ;
            conv_cnt_reg <= '0;
            conv_cfg_reg <= `ACSR_CFG_DEFAULT;
        end else begin
            case (state_reg)
                acsr_pkg::ST_ACQ: begin
                    if (cnv_rise) begin
                        state_reg <= acsr_pkg::ST_CONV;
                        conv_cnt_reg <= '0;
                        conv_cfg_reg <= active_cfg_reg;
                    end
                end
                acsr_pkg::ST_CONV: begin
                    conv_cnt_reg <= conv_cnt_reg + 16'h1;
                    if (conv_end) begin
                        state_reg <= acsr_pkg::ST_ACQ;
                    end
                end
                default: state_reg <= acsr_pkg::ST_ACQ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration capture and staging
    logic [`ACSR_CFG_W-1:0] rx_sh_reg;
    logic [3:0] rx_cnt_reg;
    logic [`ACSR_CFG_W-1:0] rx_word;

    assign rx_word = {rx_sh_reg[`ACSR_CFG_W-2:0], din_s[1]};

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_sh_reg <= '0;
            rx_cnt_reg <= '0;
        end else if (cnv_s[1]) begin
            rx_cnt_reg <= '0;
        end else if (sck_rise && rx_cnt_reg < 4'(`ACSR_CFG_W)) begin
            rx_sh_reg <= rx_word;
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
        end
    end

    // Word waits for conversion end, so it governs the next acquisition
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pend_cfg_reg <= `ACSR_CFG_DEFAULT;
            pend_valid_reg <= 1'b0;
            active_cfg_reg <= `ACSR_CFG_DEFAULT;
        end else begin
            if (conv_end && pend_valid_reg) begin
                active_cfg_reg <= pend_cfg_reg;
            end
            if (sck_rise && rx_cnt_reg == 4'(`ACSR_CFG_W - 1)
                && rx_word[`ACSR_CFG_UPD_BIT]) begin
                pend_cfg_reg <= rx_word;
                pend_valid_reg <= 1'b1;
            end else if (conv_end) begin
                pend_valid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result buffer between converter and serial port
    acsr_pkg::acsr_sample_t push_smp;
    acsr_pkg::acsr_sample_t pop_smp;
    acsr_pkg::acsr_sample_t last_smp_reg;
    logic temp_chan;
    logic bipolar;

    assign temp_chan = conv_cfg_reg[`ACSR_CFG_INCC_HI:`ACSR_CFG_INCC_LO] == `ACSR_INCC_TEMP;
    assign bipolar = !conv_cfg_reg[`ACSR_CFG_INCC_HI] && !temp_chan;
    assign push_smp.cfg = conv_cfg_reg;
    // Raw code is offset binary; sensor stays straight binary
    assign push_smp.data = bipolar ? adc_raw_i ^ `ACSR_SIGN_FLIP : adc_raw_i;

    // A full buffer drops the new result rather than stalling conversion
    acsr_fifo #(
        .W($bits(acsr_pkg::acsr_sample_t)),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(conv_end),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_smp),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(cnv_fall),
        .out_data_o(pop_smp)
    );

    ////////////////////////////////////////////////////////////////////////
    // Serial output
    logic [TXW-1:0] tx_sh_reg;
    logic [5:0] tx_cnt_reg;
    logic sdo_reg;
    logic sdo_oe_reg;
    acsr_pkg::acsr_sample_t tx_smp;
    logic [`ACSR_CFG_W-1:0] tx_cfg;

    assign tx_smp = fifo_out_valid ? pop_smp : last_smp_reg;
    // Readback off sends zeros after the result
    assign tx_cfg = tx_smp.cfg[`ACSR_CFG_RB_BIT] ? '0 : tx_smp.cfg;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_sh_reg <= '0;
            tx_cnt_reg <= '0;
            last_smp_reg <= '0;
        end else if (cnv_fall) begin
            last_smp_reg <= tx_smp;
            tx_cnt_reg <= '0;
            if (busy_mode_reg) begin
                // Leading busy bit adds one falling edge
                tx_sh_reg <= {state_reg == acsr_pkg::ST_ACQ, tx_smp.data, tx_cfg};
            end else begin
                tx_sh_reg <= {tx_smp.data, tx_cfg, 1'b0};
            end
        end else begin
            if (sck_fall) begin
                tx_sh_reg <= {tx_sh_reg[TXW-2:0], 1'b0};
                tx_cnt_reg <= tx_cnt_reg + 6'h1;
            end else if (conv_end && busy_mode_reg && tx_cnt_reg == '0) begin
                tx_sh_reg[TXW-1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sdo_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
        end else begin
            sdo_reg <= tx_sh_reg[TXW-1];
            sdo_oe_reg <= !cnv_s[1] && !cnv_s[2];
        end
    end
    assign sdo_o = sdo_reg;
    assign sdo_oe_o = sdo_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // Analog control outputs
    acsr_pkg::acsr_ref_ctl_t ref_ctl;
    logic pwr_reg;
    logic corr_reg;
    acsr_pkg::acsr_ref_ctl_t ref_reg;
    logic [6:0] mux_reg;

    assign ref_ctl = acsr_pkg::acsr_ref_decode(active_cfg_reg[`ACSR_CFG_REF_HI:`ACSR_CFG_REF_LO]);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pwr_reg <= 1'b0;
            corr_reg <= 1'b0;
        end else begin
            pwr_reg <= state_reg == acsr_pkg::ST_CONV && !conv_end;
            corr_reg <= state_reg == acsr_pkg::ST_CONV && conv_cnt_reg < data_cyc_reg;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_reg <= '0;
            mux_reg <= '0;
        end else begin
            ref_reg <= ref_ctl;
            mux_reg <= active_cfg_reg[`ACSR_CFG_INCC_HI:`ACSR_CFG_BW_BIT];
        end
    end

    assign analog_pwr_o = pwr_reg;
    assign err_corr_en_o = corr_reg;
    assign bandgap_en_o = ref_reg.bandgap;
    assign ref_drive_en_o = ref_reg.drive;
    assign ref_4v096_o = ref_reg.v4096;
    assign ref_buf_en_o = ref_reg.buf_en;
    assign temp_sensor_en_o = ref_reg.temp;
    assign input_cfg_o = mux_reg[6:4];
    assign chan_sel_o = mux_reg[3:1];
    assign bw_quarter_o = !mux_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_conv_start_rise: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == acsr_pkg::ST_ACQ && cnv_rise |=> state_reg == acsr_pkg::ST_CONV)
        else $error("conversion did not start on pin rise");
    a_access_gated_high: assert property (@(posedge clk_i) disable iff (reset_i)
        cnv_s[1] |=> rx_cnt_reg == '0 && $stable(tx_cnt_reg))
        else $error("serial activity while start pin high");
    a_cfg_word_capture: assert property (@(posedge clk_i) disable iff (reset_i)
        sck_rise && rx_cnt_reg == 4'hD && rx_word[13] |=> pend_valid_reg
        && pend_cfg_reg == $past(rx_word))
        else $error("configuration word not captured at 14th edge");
    a_cfg_next_conv: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_end && pend_valid_reg |=> active_cfg_reg == $past(pend_cfg_reg))
        else $error("staged configuration not applied at conversion end");
    a_power_down_end: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_end |=> !analog_pwr_o ##1 (!analog_pwr_o || state_reg == acsr_pkg::ST_CONV))
        else $error("converter not powered down after conversion");
    a_corr_window_off: assert property (@(posedge clk_i) disable iff (reset_i)
        state_reg == acsr_pkg::ST_CONV && conv_cnt_reg >= data_cyc_reg |=> !err_corr_en_o)
        else $error("correction active after safe access time");
    a_temp_needs_ref: assert property (@(posedge clk_i) disable iff (reset_i)
        temp_sensor_en_o |-> bandgap_en_o)
        else $error("temperature sensor without reference");
    a_sdo_release_high: assert property (@(posedge clk_i) disable iff (reset_i)
        cnv_s[2] |=> !sdo_oe_o)
        else $error("serial output driven while start pin high");
    a_temp_straight_bin: assert property (@(posedge clk_i) disable iff (reset_i)
        conv_end && temp_chan |-> push_smp.data == adc_raw_i)
        else $error("temperature result not straight binary");
endmodule : acsr_top

// >>> verif/acsr_host_model.sv
// Host serial master model for the converter's access pins
`timescale 1ns/10ps
module acsr_host_model (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic pin_o,
    output logic sck_o,
    output logic din_o,
    output logic [29:0] rx_word_o,
    output logic rx_done_o
);
    initial begin
        pin_o = 1'b1;
        sck_o = 1'b0;
        din_o = 1'b0;
        rx_word_o = '0;
        rx_done_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One access of 30 clocks; sck idles low between accesses
    task automatic access(input logic [13:0] word);
        logic [29:0] r;
        r = '0;
        pin_o <= 1'b0;
        repeat (10) @(posedge clk_i);
        for (int k = 0; k < 30; k++) begin
            din_o <= (k < 14) ? word[13 - k] : ~din_o;
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            // Sampled late: the output trails each fall by four clocks
            r = {r[28:0], sdo_i};
            sck_o <= 1'b0;
        end
        // Quiet pins well past 20 ns around the pin rise
        repeat (4) @(posedge clk_i);
        pin_o <= 1'b1;
        rx_word_o <= r;
        rx_done_o <= 1'b1;
        @(posedge clk_i);
        rx_done_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : access
    // Deliberate clocking while deselected, which must be ignored
    task automatic stray();
        din_o <= 1'b0;
        repeat (14) begin
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b0;
        end
        @(posedge clk_i);
    endtask : stray
endmodule : acsr_host_model

// >>> verif/acsr_top_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`include "acsr_regs.svh"
module acsr_top_test;
    logic clk_i, reset_i, pin, sck, din, sdo_o, sdo_oe_o, sdo_line, rd_d, rx_done;
    logic reg_wr_i, reg_rd_i, analog_pwr_o, err_corr_en_o, bw_quarter_o;
    logic bandgap_en_o, ref_drive_en_o, ref_4v096_o, ref_buf_en_o, temp_sensor_en_o;
    logic [15:0] adc_raw_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, seed;
    logic [2:0] input_cfg_o, chan_sel_o, rc, inc;
    logic [29:0] rx_word, exp_s;
    logic [13:0] w, act, pend;
    logic [30:0] sq[$];
    logic [31:0] rq[$];
    int bad_count, checked;

    assign sdo_line = sdo_oe_o ? sdo_o : 1'b1;

    acsr_top #(.FIFO_DEPTH(8)) uut (.clk_i(clk_i), .reset_i(reset_i), .conv_start_pin_i(pin),
        .sck_i(sck), .din_i(din), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .adc_raw_i(adc_raw_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .analog_pwr_o(analog_pwr_o),
        .err_corr_en_o(err_corr_en_o), .bandgap_en_o(bandgap_en_o),
        .ref_drive_en_o(ref_drive_en_o), .ref_4v096_o(ref_4v096_o),
        .ref_buf_en_o(ref_buf_en_o), .temp_sensor_en_o(temp_sensor_en_o),
        .input_cfg_o(input_cfg_o), .chan_sel_o(chan_sel_o), .bw_quarter_o(bw_quarter_o));

    acsr_host_model host (.clk_i(clk_i), .sdo_i(sdo_line), .pin_o(pin), .sck_o(sck),
        .din_o(din), .rx_word_o(rx_word), .rx_done_o(rx_done));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // Bipolar modes flip the sign bit; the temperature channel stays straight
    function automatic logic [15:0] xf(input logic [15:0] r, input logic [13:0] c);
        return (!c[12] && c[12:10] != 3'h3) ? r ^ 16'h8000 : r;
    endfunction : xf
    function automatic logic [4:0] ref_exp(input logic [2:0] c);
        case (c)
            3'h0: return 5'h1B;
            3'h1: return 5'h1F;
            3'h2: return 5'h13;
            3'h3: return 5'h11;
            3'h7: return 5'h02;
            default: return 5'h00;
        endcase
    endfunction : ref_exp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////////
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : reg_read
    task automatic run_conv();
        int n, pc, ec;
        n = 0;
        pc = 0;
        ec = 0;
        while (analog_pwr_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        while (analog_pwr_o === 1'b1 && pc < 100) begin
            ec += (err_corr_en_o === 1'b1);
            pc++;
            @(negedge clk_i);
        end
        check(ec, 8);
        check(pc, 32'h13);
        repeat (3) @(negedge clk_i);
        check(sdo_oe_o, 1'b0);
        check({bandgap_en_o, ref_drive_en_o, ref_4v096_o, ref_buf_en_o, temp_sensor_en_o},
            ref_exp(act[5:3]));
        check({input_cfg_o, chan_sel_o, bw_quarter_o}, {act[12:7], ~act[6]});
        @(posedge clk_i);
    endtask : run_conv
    ////////////////////////////////////////////////////////////////////////////////
    // Result watchers take the oldest note as each result appears
    always @(posedge clk_i) rd_d <= reg_rd_i;
    always @(negedge clk_i) if (rd_d) check(reg_rdata_o, rq.pop_front());
    always @(posedge rx_done) begin
        if (sq[0][30]) check({2'h0, rx_word}, {2'h0, sq[0][29:0]});
        void'(sq.pop_front());
    end

    initial begin
        reset_i = 1'b1;
        adc_raw_i = '0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        rd_d = 1'b0;
        bad_count = 0;
        checked = 0;
        seed = 32'h38;
        act = 14'h3FFF;
        pend = 14'h3FFF;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        reg_read(`ACSR_ADDR_CONV_CYC, 32'h6E);
        reg_read(`ACSR_ADDR_DATA_CYC, 32'h3C);
        reg_read(`ACSR_ADDR_CTRL, 32'h0);
        reg_read(`ACSR_ADDR_STATUS, 32'h8);
        reg_read(`ACSR_ADDR_ACTIVE_CFG, 32'h3FFF);
        reg_read(`ACSR_ADDR_PEND_CFG, 32'h3FFF);
        reg_read(8'h20, 32'h0);
        reg_write(`ACSR_ADDR_CONV_CYC, 32'h14);
        reg_write(`ACSR_ADDR_DATA_CYC, 32'h8);
        reg_write(`ACSR_ADDR_CTRL, 32'h1);
        reg_read(`ACSR_ADDR_CTRL, 32'h1);
        reg_write(`ACSR_ADDR_CTRL, 32'h0);
        reg_read(`ACSR_ADDR_CONV_CYC, 32'h14);
        $display("register test done");
        // Two all-ones dummy loads, then every reference code once
        for (int i = 0; i < 11; i++) begin
            seed = xs(seed);
            rc = 3'(i - 2);
            inc = (i % 3 == 0) ? 3'h7 : (i % 3 == 1) ? 3'h3 : 3'h2;
            w = (i < 2 || i == 10) ? 14'h3FFF : {1'b1, inc, seed[2:0], seed[3], rc, 2'h0, rc[0]};
            if (i == 10) w[13] = 1'b0;
            adc_raw_i <= seed[31:16];
            if (i == 8) reg_write(`ACSR_ADDR_CTRL, 32'h1);
            sq.push_back({i != 0, (i >= 8) ? {1'b1, exp_s[29:1]} : exp_s});
            host.access(w);
            if (w[13]) pend = w;
            exp_s = {xf(seed[31:16], act), act[0] ? 14'h0 : act};
            act = pend;
            run_conv();
            if (i == 3) begin
                host.stray();
                reg_read(`ACSR_ADDR_PEND_CFG, {18'h0, pend});
                reg_read(`ACSR_ADDR_ACTIVE_CFG, {18'h0, act});
                reg_read(`ACSR_ADDR_STATUS, 32'h0);
            end
        end
        $display("serial test done");
        repeat (20) @(posedge clk_i);
        summarize();
    end

    initial begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule : acsr_top_test
